/* File: logic/mspcd_pkg.sv */
`default_nettype none
package mspcd_pkg;
	// ==========================================================
	// opcode values of the command set
	localparam logic [7:0] OP_STOP  = 8'h00;
	localparam logic [7:0] OP_CONT  = 8'h11;
	localparam logic [7:0] OP_SRP   = 8'h33;
	localparam logic [7:0] OP_CRP   = 8'h44;
	localparam logic [7:0] OP_WRITE_PARAM_CMD  = 8'h55;
	localparam logic [7:0] OP_LOAD_SETTINGS1_CMD = 8'h66;
	localparam logic [7:0] OP_THR1  = 8'h77;
	localparam logic [7:0] OP_OUTPUT_COPY_CMD  = 8'h88;
	localparam logic [7:0] OP_OUTPUT_WAIT_CMD  = 8'h99;
	localparam logic [7:0] OP_THR2  = 8'haa;
	localparam logic [7:0] OP_DEC   = 8'hbb;
	localparam logic [7:0] OP_SIGN_SWAP_CMD  = 8'hcc;
	localparam logic [7:0] OP_FREE  = 8'hdd;
	localparam logic [7:0] OP_THR3  = 8'hee;
	localparam logic [7:0] OP_SYNC  = 8'hff;
	localparam logic [7:0] OP_UFILT = 8'h12;
	localparam logic [7:0] OP_SFILT = 8'h13;
	localparam logic [7:0] OP_MAIN  = 8'h14;
	localparam logic [7:0] OP_RAW   = 8'h21;
	localparam logic [7:0] OP_DIFF  = 8'h23;
	localparam logic [7:0] OP_ALT   = 8'h24;
	localparam logic [7:0] OP_DMODE = 8'h31;
	localparam logic [7:0] OP_SHIFT = 8'h32;
	localparam logic [7:0] OP_KEEPM = 8'h34;
	localparam logic [7:0] OP_TIM3  = 8'h41;
	localparam logic [7:0] OP_TIM4  = 8'h42;
	localparam logic [7:0] OP_FREEM = 8'h43;
	// ==========================================================
	// register memory map (byte addresses, 7-bit space)
	localparam int         MEM_DEPTH  = 128;
	localparam logic [6:0] CFG1_BASE  = 7'h00;
	localparam logic [6:0] CFG2_BASE  = 7'h10;
	localparam logic [6:0] PROG1_BASE = 7'h40;
	localparam logic [6:0] PROG2_BASE = 7'h60;
	localparam logic [6:0] SETT_OFS   = 7'h00;
	localparam logic [6:0] THR1_OFS   = 7'h01;
	localparam logic [6:0] THR2_OFS   = 7'h02;
	localparam logic [6:0] TIM3_OFS   = 7'h03;
	localparam logic [6:0] TIM4_OFS   = 7'h04;
	localparam logic [6:0] MASKM_OFS  = 7'h05;
	localparam logic [6:0] MASKA_OFS  = 7'h06;
	localparam logic [6:0] LCNT_OFS   = 7'h07;
	localparam logic [6:0] PTR_OFS    = 7'h08;
	localparam logic [6:0] OUTS_OFS   = 7'h09;
	localparam logic [6:0] SETT1_ADDR = 7'h20;
	localparam logic [6:0] THR3_ADDR  = 7'h21;
	localparam logic [6:0] CTRL_ADDR  = 7'h22;
	localparam logic [6:0] STAT_ADDR  = 7'h23;
	// ==========================================================
	// bit positions in each program_settings_reg
	localparam int SIGNED_FILTER_BIT  = 0;
	localparam int DIFFERENCE_MODE_BIT = 1;
	localparam int SHIFT_MODE_BIT     = 2;
	localparam int TEMP_MASK_REL_BIT  = 3;
	localparam int MASK_SELECT_BIT    = 4;
	localparam int STOP_CONT_OUT_BIT  = 5;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// ==========================================================
	typedef enum logic [1:0] {MSPCD_FETCH, MSPCD_ARG1, MSPCD_ARG2, MSPCD_EXEC} mspcd_fsm_e;
	// events from the condition unit, one lane per program
	typedef struct packed {
		logic [1:0]      load;  // one-cycle pulse: take new flags
		logic [1:0][7:0] tmp;   // temporary output flags
		logic [1:0][7:0] trig;  // trigger direction info
	} mspcd_evt_s;
	// program state seen by the condition unit
	typedef struct packed {
		logic [1:0]      run;    // program enabled and not waiting
		logic [1:0]      whost;  // parked on output wait
		logic [1:0]      wsync;  // parked on sync point
		logic [1:0][7:0] trig;   // current trigger info
	} mspcd_stat_s;
endpackage : mspcd_pkg
`default_nettype wire

/* File: logic/mspcd_decoder.sv */
// Summary of operation
// - restart-point clear returns reset point to start
// - write-param stores value byte at given address
// - load-settings1 writes byte to settings1 register
// - threshold loads write first, second, shared threshold
// - output copy latches flags, execution continues
// - output wait latches, halts until host release
// - count down decrements counter, decides flow
// - sign swap inverts directions in mask, trigger
// - free temp output clears temporary flags
// - sync point waits for the other program
// - filter commands clear or set signed bit
// - mask commands pick main or alternate mask
// - program two raw/difference sets difference bit
// - program two diff/shift sets shift bit
// - temp mask commands clear or set release bit
// - timer loads write timer3 or timer4 register
// - program-two-only codes halt program one
// - host read of output flags clears them
// - stop/continue latch outputs when bit set
`timescale 1ns/10ps
`default_nettype none
module mspcd_decoder
	import mspcd_pkg::*;
(
	input  wire logic        clk_sys_i,  // 100 MHz sample clock
	input  wire logic        rst_i,      // synchronous, active high
	input  wire logic [6:0]  addr_i,     // register byte address
	input  wire logic [7:0]  wdata_i,    // write data
	input  wire logic        we_i,       // write strobe
	input  wire logic        re_i,       // read strobe
	input  wire mspcd_evt_s  evt_i,      // condition unit events
	output logic      [7:0]  rdata_o,    // read data, cycle after strobe
	output mspcd_stat_s      stat_o      // program state
);
	// ==========================================================
	// state
	typedef struct packed {
		logic [MEM_DEPTH-1:0][7:0] mem;    // register and program memory
		mspcd_fsm_e                fsm;    // decoder step
		logic                      cur;    // program being served
		logic [7:0]                op;     // opcode in execution
		logic [7:0]                a1;     // first argument byte
		logic [1:0]                whost;  // waiting on latch reset
		logic [1:0]                wsync;  // waiting at sync point
		logic [1:0][7:0]           tmp;    // temporary output info
		logic [1:0][7:0]           trig;   // trigger info
		logic [7:0]                rdata;  // registered read data
	} mspcd_st_s;

	mspcd_st_s s;       // current state
	mspcd_st_s next_s;  // next state

	// ==========================================================
	// addressing of the program being served
	logic [6:0] cfg;      // settings block of current program
	logic [6:0] pbase;    // code base of current program
	logic [7:0] ptr;      // reset point high nibble, pointer low
	logic [7:0] code;     // byte under the program pointer
	logic [6:0] sadr;     // settings register address
	logic [6:0] madr;     // selected axis mask address
	logic [1:0] en;       // program enable flags
	logic       runnable; // current program may step

	assign cfg      = s.cur ? CFG2_BASE : CFG1_BASE;
	assign pbase    = s.cur ? PROG2_BASE : PROG1_BASE;
	assign ptr      = s.mem[cfg + PTR_OFS];
	assign code     = s.mem[pbase + {3'h0, ptr[3:0]}];
	assign sadr     = cfg + SETT_OFS;
	assign madr     = cfg + (s.mem[sadr][MASK_SELECT_BIT] ? MASKA_OFS : MASKM_OFS);
	assign en       = s.mem[CTRL_ADDR][1:0];
	assign runnable = en[s.cur] & ~s.whost[s.cur] & ~s.wsync[s.cur];

	// swap plus/minus pairs of every axis
	function automatic logic [7:0] swap_sign(input logic [7:0] v);
		swap_sign = {v[6], v[7], v[4], v[5], v[2], v[3], v[0], v[1]};
	endfunction : swap_sign

	// the map assumes the memory spans the whole byte address space
	if (MEM_DEPTH != 2 ** $bits(addr_i)) begin : g_depth_check
		$error("memory depth does not match the address space");
	end

	// ==========================================================
	// next-state logic
	always_comb begin
		logic [7:0] cnt;    // decremented long counter
		logic       latch;  // latch outputs this cycle
		cnt    = s.mem[cfg + LCNT_OFS] - 8'h01;
		latch  = 1'b0;
		next_s = s;
		next_s.rdata = RESET_BYTE;
		// host read; clearing here first lets a latch below win
		if (re_i) begin
			next_s.rdata = (addr_i == STAT_ADDR) ?
				{2'h0, s.wsync, s.whost, en} : s.mem[addr_i];
			if (addr_i == CFG1_BASE + OUTS_OFS) begin
				next_s.mem[addr_i] = RESET_BYTE;
				next_s.whost[0]    = 1'b0;
			end
			if (addr_i == CFG2_BASE + OUTS_OFS) begin
				next_s.mem[addr_i] = RESET_BYTE;
				next_s.whost[1]    = 1'b0;
			end
		end
		// decoder steps
		case (s.fsm)
			MSPCD_FETCH: begin
				if (runnable) begin
					next_s.op = code;
					next_s.mem[cfg + PTR_OFS] = {ptr[7:4], ptr[3:0] + 4'h1};
					case (code)
						OP_WRITE_PARAM_CMD, OP_LOAD_SETTINGS1_CMD, OP_THR1, OP_THR2, OP_THR3, OP_TIM3, OP_TIM4:
							next_s.fsm = MSPCD_ARG1;
						default: next_s.fsm = MSPCD_EXEC;
					endcase
				end else begin
					next_s.cur = ~s.cur;  // idle program gives up its turn
				end
			end
			MSPCD_ARG1: begin
				next_s.a1 = code;
				next_s.mem[cfg + PTR_OFS] = {ptr[7:4], ptr[3:0] + 4'h1};
				next_s.fsm = (s.op == OP_WRITE_PARAM_CMD) ? MSPCD_ARG2 : MSPCD_EXEC;
			end
			MSPCD_ARG2: begin
				// value byte goes straight to its absolute address
				next_s.mem[s.a1[6:0]] = code;
				next_s.mem[cfg + PTR_OFS] = {ptr[7:4], ptr[3:0] + 4'h1};
				next_s.fsm = MSPCD_FETCH;
				next_s.cur = ~s.cur;
			end
			MSPCD_EXEC: begin
				next_s.fsm = MSPCD_FETCH;
				next_s.cur = ~s.cur;
				case (s.op)
					OP_STOP: begin
						next_s.mem[cfg + PTR_OFS] = 8'h00;
						next_s.mem[CTRL_ADDR][s.cur] = 1'b0;
						latch = s.mem[sadr][STOP_CONT_OUT_BIT];
					end
					OP_CONT: begin
						next_s.mem[cfg + PTR_OFS] = {ptr[7:4], ptr[7:4]};
						latch = s.mem[sadr][STOP_CONT_OUT_BIT];
					end
					OP_SRP:   next_s.mem[cfg + PTR_OFS] = {ptr[3:0], ptr[3:0]};
					OP_CRP:   next_s.mem[cfg + PTR_OFS] = {4'h0, ptr[3:0]};
					OP_LOAD_SETTINGS1_CMD: next_s.mem[SETT1_ADDR] = s.a1;
					OP_THR1:  next_s.mem[cfg + THR1_OFS] = s.a1;
					OP_THR2:  next_s.mem[cfg + THR2_OFS] = s.a1;
					OP_THR3:  next_s.mem[THR3_ADDR] = s.a1;
					OP_TIM3:  next_s.mem[cfg + TIM3_OFS] = s.a1;
					OP_TIM4:  next_s.mem[cfg + TIM4_OFS] = s.a1;
					OP_OUTPUT_COPY_CMD:  latch = 1'b1;
					OP_OUTPUT_WAIT_CMD: begin
						latch = 1'b1;
						next_s.whost[s.cur] = 1'b1;
					end
					OP_DEC: begin
						next_s.mem[cfg + LCNT_OFS] = cnt;
						// nonzero loops back to the reset point, zero falls through
						if (cnt != 8'h00) begin
							next_s.mem[cfg + PTR_OFS] = {ptr[7:4], ptr[7:4]};
						end
					end
					OP_SIGN_SWAP_CMD: begin
						next_s.mem[madr]     = swap_sign(s.mem[madr]);
						next_s.trig[s.cur]   = swap_sign(s.trig[s.cur]);
					end
					OP_FREE:  next_s.tmp[s.cur] = RESET_BYTE;
					OP_SYNC:  next_s.wsync[s.cur] = 1'b1;
					OP_UFILT: next_s.mem[sadr][SIGNED_FILTER_BIT] = 1'b0;
					OP_SFILT: next_s.mem[sadr][SIGNED_FILTER_BIT] = 1'b1;
					OP_MAIN:  next_s.mem[sadr][MASK_SELECT_BIT] = 1'b0;
					OP_ALT:   next_s.mem[sadr][MASK_SELECT_BIT] = 1'b1;
					OP_KEEPM: next_s.mem[sadr][TEMP_MASK_REL_BIT] = 1'b0;
					OP_FREEM: next_s.mem[sadr][TEMP_MASK_REL_BIT] = 1'b1;
					OP_RAW, OP_DIFF, OP_DMODE, OP_SHIFT: begin
						if (!s.cur) begin
							// program one may not touch data modes: halt it
							next_s.mem[CTRL_ADDR][0] = 1'b0;
						end else if (s.op == OP_RAW || s.op == OP_DIFF) begin
							next_s.mem[sadr][DIFFERENCE_MODE_BIT] = (s.op == OP_DIFF);
						end else begin
							next_s.mem[sadr][SHIFT_MODE_BIT] = (s.op == OP_SHIFT);
						end
					end
					default: ;  // condition codes belong to the condition unit
				endcase
			end
			default: next_s.fsm = MSPCD_FETCH;
		endcase
		// output latch happens after the read clear, so the set wins
		if (latch) begin
			next_s.mem[cfg + OUTS_OFS] = s.tmp[s.cur];
		end
		// both programs at the sync point, or the partner stopped: release
		if ((s.wsync[0] | ~en[0]) & (s.wsync[1] | ~en[1])) begin
			next_s.wsync = 2'b00;
		end
		// new condition flags override a free or sign swap in the same cycle
		for (int i = 0; i < 2; i++) begin
			if (evt_i.load[i]) begin
				next_s.tmp[i]  = evt_i.tmp[i];
				next_s.trig[i] = evt_i.trig[i];
			end
		end
		// host write comes last; status register is read-only
		if (we_i && addr_i != STAT_ADDR) begin
			next_s.mem[addr_i] = wdata_i;
		end
	end

	// ==========================================================
	// state register
	// one register stage for all state; reset clears the memory as well
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// outputs
	assign rdata_o      = s.rdata;
	assign stat_o.run   = en & ~s.whost & ~s.wsync;
	assign stat_o.whost = s.whost;
	assign stat_o.wsync = s.wsync;
	assign stat_o.trig  = s.trig;

	// ==========================================================
	// checks
	logic ex_now;  // executing this cycle
	assign ex_now = (s.fsm == MSPCD_EXEC);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	chk_crp_rp_clear: assert property ((ex_now && s.op == OP_CRP && !we_i) |=>
		(s.mem[$past(cfg) + PTR_OFS][7:4] == 4'h0)) else $error("reset point not cleared");
	chk_write_param_cmd_store: assert property ((s.fsm == MSPCD_ARG2 && !we_i && !re_i) |=>
		(s.mem[$past(s.a1[6:0])] == $past(code))) else $error("parameter not stored");
	chk_load_settings1_cmd_load: assert property ((ex_now && s.op == OP_LOAD_SETTINGS1_CMD && !we_i) |=>
		(s.mem[SETT1_ADDR] == $past(s.a1))) else $error("settings1 not loaded");
	chk_thr1_load: assert property ((ex_now && s.op == OP_THR1 && !we_i) |=>
		(s.mem[$past(cfg) + THR1_OFS] == $past(s.a1))) else $error("threshold1 not loaded");
	chk_output_copy_cmd_latch: assert property ((ex_now && s.op == OP_OUTPUT_COPY_CMD && !we_i) |=>
		(s.mem[$past(cfg) + OUTS_OFS] == $past(s.tmp[s.cur]))) else $error("outputs not copied");
	chk_output_wait_cmd_park: assert property ((ex_now && s.op == OP_OUTPUT_WAIT_CMD && !s.cur) |=>
		(s.whost[0] && s.fsm == MSPCD_FETCH)) else $error("output wait did not park");
	chk_forbid_halt: assert property ((ex_now && !s.cur && s.op == OP_RAW && !we_i) |=>
		!en[0]) else $error("program one not halted");
	chk_read_clear: assert property ((re_i && !we_i && addr_i == CFG1_BASE + OUTS_OFS &&
		!ex_now) |=> (s.mem[CFG1_BASE + OUTS_OFS] == 8'h00 && !s.whost[0]))
		else $error("output flags not cleared");
	chk_sync_release: assert property ((s.wsync == 2'b11) |=> (s.wsync == 2'b00))
		else $error("sync point not released");
	chk_args_skip: assert property ((s.fsm == MSPCD_FETCH && runnable && code == OP_WRITE_PARAM_CMD &&
		!we_i) |=> s.fsm == MSPCD_ARG1 ##1 s.fsm == MSPCD_ARG2 ##1 s.fsm == MSPCD_FETCH)
		else $error("argument bytes not consumed");
	// remaining loads land where the opcode says
	chk_thr2_load: assert property ((ex_now && s.op == OP_THR2 && !we_i) |=>
		(s.mem[$past(cfg) + THR2_OFS] == $past(s.a1))) else $error("threshold2 not loaded");
	chk_thr3_load: assert property ((ex_now && s.op == OP_THR3 && !we_i) |=>
		(s.mem[THR3_ADDR] == $past(s.a1))) else $error("shared threshold not loaded");
	chk_tim3_load: assert property ((ex_now && s.op == OP_TIM3 && !we_i) |=>
		(s.mem[$past(cfg) + TIM3_OFS] == $past(s.a1))) else $error("timer3 not loaded");
	chk_tim4_load: assert property ((ex_now && s.op == OP_TIM4 && !we_i) |=>
		(s.mem[$past(cfg) + TIM4_OFS] == $past(s.a1))) else $error("timer4 not loaded");
	// counter, sign, flag and mode commands
	chk_dec_count: assert property ((ex_now && s.op == OP_DEC && !we_i) |=>
		(s.mem[$past(cfg) + LCNT_OFS] == $past(s.mem[cfg + LCNT_OFS]) - 8'h01))
		else $error("long counter not decremented");
	chk_dec_loop: assert property ((ex_now && s.op == OP_DEC && !we_i &&
		s.mem[cfg + LCNT_OFS] != 8'h01) |=> (s.mem[$past(cfg) + PTR_OFS][3:0] == $past(ptr[7:4])))
		else $error("count down did not loop");
	chk_sign_swap_cmd_trig: assert property ((ex_now && s.op == OP_SIGN_SWAP_CMD &&
		!evt_i.load[s.cur]) |=> (s.trig[$past(s.cur)] ==
		((($past(s.trig[s.cur]) & 8'h55) << 1) | (($past(s.trig[s.cur]) & 8'haa) >> 1))))
		else $error("trigger sign not swapped");
	chk_free_tmp: assert property ((ex_now && s.op == OP_FREE &&
		!evt_i.load[s.cur]) |=> (s.tmp[$past(s.cur)] == 8'h00))
		else $error("temporary output kept");
	chk_sync_park: assert property ((ex_now && s.op == OP_SYNC && en[s.cur]) |=>
		s.wsync[$past(s.cur)]) else $error("sync point did not park");
	chk_stop_latch: assert property ((ex_now && s.op == OP_STOP && !we_i &&
		s.mem[sadr][STOP_CONT_OUT_BIT]) |=> (s.mem[$past(cfg) + OUTS_OFS] == $past(s.tmp[s.cur])))
		else $error("stop did not latch outputs");
	chk_signed_filt: assert property ((ex_now && s.op == OP_SFILT && !we_i) |=>
		s.mem[$past(sadr)][SIGNED_FILTER_BIT]) else $error("signed filter not set");
	chk_alt_mask: assert property ((ex_now && s.op == OP_ALT && !we_i) |=>
		s.mem[$past(sadr)][MASK_SELECT_BIT]) else $error("alternate mask not picked");
	chk_diff_mode: assert property ((ex_now && s.cur && s.op == OP_DIFF && !we_i) |=>
		s.mem[$past(sadr)][DIFFERENCE_MODE_BIT]) else $error("difference mode not set");
	chk_shift_mode: assert property ((ex_now && s.cur && s.op == OP_SHIFT && !we_i) |=>
		s.mem[$past(sadr)][SHIFT_MODE_BIT]) else $error("shift mode not set");
	chk_read_clear2: assert property ((re_i && !we_i && addr_i == CFG2_BASE + OUTS_OFS &&
		!ex_now) |=> (s.mem[CFG2_BASE + OUTS_OFS] == 8'h00 && !s.whost[1]))
		else $error("program two flags not cleared");

	cov_output_wait_cmd_release: cover property (s.whost[0] ##[1:50] !s.whost[0]);
	cov_write_param_cmd: cover property (s.fsm == MSPCD_ARG2);
	cov_sync: cover property (s.wsync == 2'b11);
	cov_forbid: cover property (ex_now && !s.cur && s.op == OP_SHIFT);
	cov_stop_latch: cover property (ex_now && s.op == OP_STOP && s.mem[sadr][STOP_CONT_OUT_BIT]);
endmodule : mspcd_decoder
`default_nettype wire

/* File: testbench/mspcd_cond_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// condition unit stand-in: one-cycle load pulse per program lane
module mspcd_cond_model
	import mspcd_pkg::*;
(
	input  wire logic       clk_sys_i, // sample clock
	input  wire logic       rst_i,     // synchronous reset
	input  wire logic [1:0] go_i,      // request a load pulse per lane
	input  wire logic [7:0] tmp_i,     // temporary flags to hand over
	input  wire logic [7:0] trig_i,    // trigger info to hand over
	output var  mspcd_evt_s evt_o      // events towards the decoder
);
	// outside a pulse the data lanes flip every cycle, so a decoder that
	// samples them one cycle late never sees the intended value by luck
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			evt_o <= '0;
		end else if (|go_i) begin
			evt_o.load <= go_i;
			evt_o.tmp  <= {tmp_i, tmp_i};
			evt_o.trig <= {trig_i, trig_i};
		end else begin
			evt_o.load <= 2'b00;
			evt_o.tmp  <= ~evt_o.tmp;
			evt_o.trig <= ~evt_o.trig;
		end
	end
endmodule : mspcd_cond_model
`default_nettype wire

/* File: testbench/test_motion_state_program_command_decoder.sv */
`timescale 1ns/10ps
`default_nettype none
module test_motion_state_program_command_decoder
	import mspcd_pkg::*;
;
	// ==========================================================
	// stimulus and observed signals
	logic        clk_sys_i, rst_i, we_i, re_i; // clock, reset, strobes
	logic [6:0]  addr_i;                       // register address
	logic [7:0]  wdata_i, rdata_o, d;          // data lanes, scratch
	logic [1:0]  go;                           // event request per lane
	logic [7:0]  tmp_v, trig_v;                // event payload
	mspcd_evt_s  evt;                          // events into the decoder
	mspcd_stat_s stat;                         // program state out
	int          errors    = 0;                // mismatches seen
	int          cmp_count = 0;                // comparisons made
	logic [7:0]  bad [4] = '{8'h21, 8'h23, 8'h31, 8'h32}; // program-2-only codes

	mspcd_decoder i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .evt_i(evt), .rdata_o(rdata_o),
		.stat_o(stat));
	mspcd_cond_model i_cond (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .go_i(go),
		.tmp_i(tmp_v), .trig_i(trig_v), .evt_o(evt));

	// ==========================================================
	// clock and watchdog
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	// the whole sequence needs a few hundred cycles; give it ample margin
	initial begin
		#(30000 * 10);
		errors++;
		finish_test();
	end

	// ==========================================================
	// access tasks
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		@(posedge clk_sys_i);
		addr_i  <= a;
		wdata_i <= v;
		we_i    <= 1'b1;
		@(posedge clk_sys_i);
		we_i    <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [6:0] a, output logic [7:0] v);
		@(posedge clk_sys_i);
		addr_i <= a;
		re_i   <= 1'b1;
		@(posedge clk_sys_i);
		re_i   <= 1'b0;
		#1;
		v = rdata_o;
	endtask : rd
	// code bytes are packed first-byte-highest into c
	task automatic prog(input logic [6:0] b, input logic [127:0] c, input int n);
		for (int i = 0; i < n; i++) begin
			wr(b + 7'(i), c[8*(n-1-i) +: 8]);
		end
	endtask : prog
	// polls status under a bounded count; status reads never clear anything
	task automatic wait_st(input logic [7:0] m, input logic [7:0] v);
		logic [7:0] s;
		int         n;
		n = 0;
		do begin
			rd(STAT_ADDR, s);
			n++;
		end while (((s & m) !== v) && n < 100);
		chk("status wait", v, s & m);
	endtask : wait_st
	task automatic run(input logic [1:0] en);
		wr(CTRL_ADDR, {6'h00, en});
		wait_st(8'h03, 8'h00);
	endtask : run
	task automatic ev(input logic [1:0] l, input logic [7:0] t, input logic [7:0] g);
		@(posedge clk_sys_i);
		go     <= l;
		tmp_v  <= t;
		trig_v <= g;
		@(posedge clk_sys_i);
		go     <= 2'b00;
		@(posedge clk_sys_i);
	endtask : ev
	task automatic finish_test();
		if (errors == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : finish_test

	// ==========================================================
	// test sequence
	initial begin
		rst_i = 1'b1; we_i = 1'b0; re_i = 1'b0; addr_i = 7'h00; wdata_i = 8'h00;
		go = 2'b00; tmp_v = 8'h00; trig_v = 8'h00;
		repeat (5) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		// status is read-only and read data idle at zero
		wr(STAT_ADDR, 8'hff);
		rd(STAT_ADDR, d); chk("status", 8'h00, d);
		@(posedge clk_sys_i); #1; chk("rdata idle", 8'h00, rdata_o);
		// parameter, settings and threshold loads with argument bytes
		prog(PROG1_BASE, 96'h550e5a66a57711aa22ee3300, 12);
		run(2'b01);
		rd(7'h0e, d); chk("param", 8'h5a, d);
		rd(SETT1_ADDR, d); chk("settings1", 8'ha5, d);
		rd(CFG1_BASE + THR1_OFS, d); chk("thr1", 8'h11, d);
		rd(CFG1_BASE + THR2_OFS, d); chk("thr2", 8'h22, d);
		rd(THR3_ADDR, d); chk("thr3", 8'h33, d);
		// timers and settings bits set, then cleared
		prog(PROG1_BASE, 64'h4144425513244300, 8);
		run(2'b01);
		rd(CFG1_BASE + TIM3_OFS, d); chk("tim3", 8'h44, d);
		rd(CFG1_BASE + TIM4_OFS, d); chk("tim4", 8'h55, d);
		rd(CFG1_BASE + SETT_OFS, d); chk("settings set", 8'h19, d);
		prog(PROG1_BASE, 32'h12143400, 4);
		run(2'b01);
		rd(CFG1_BASE + SETT_OFS, d); chk("settings clr", 8'h00, d);
		// program-2-only codes stop program 1 before the next command
		foreach (bad[i]) begin
			prog(PROG1_BASE, {bad[i], 8'h13, 8'h00}, 3);
			run(2'b01);
			rd(CFG1_BASE + SETT_OFS, d); chk("forbidden halt", 8'h00, d);
			// a halt leaves the pointer mid-program; rewind for the next run
			wr(CFG1_BASE + PTR_OFS, 8'h00);
		end
		// program 2 data modes
		prog(PROG2_BASE, 24'h233200, 3);
		run(2'b10);
		rd(CFG2_BASE + SETT_OFS, d); chk("settings2 set", 8'h06, d);
		prog(PROG2_BASE, 24'h213100, 3);
		run(2'b10);
		rd(CFG2_BASE + SETT_OFS, d); chk("settings2 clr", 8'h00, d);
		// count down loops back to the reset point until zero
		wr(CFG1_BASE + LCNT_OFS, 8'h03);
		prog(PROG1_BASE, 16'hbb00, 2);
		run(2'b01);
		rd(CFG1_BASE + LCNT_OFS, d); chk("long counter", 8'h00, d);
		// sign swap on main mask and trigger info
		wr(CFG1_BASE + MASKM_OFS, 8'h81);
		ev(2'b01, 8'h00, 8'h24);
		prog(PROG1_BASE, 16'hcc00, 2);
		run(2'b01);
		// plus/minus neighbours trade places: 81 becomes 42, 24 becomes 18
		rd(CFG1_BASE + MASKM_OFS, d); chk("mask swap", 8'h42, d);
		chk("trig swap", 8'h18, stat.trig[0]);
		// reset point cleared, output wait parks until the host reads
		ev(2'b01, 8'h3c, 8'h00);
		prog(PROG1_BASE, 48'h334499dd8800, 6);
		wr(CTRL_ADDR, 8'h01);
		wait_st(8'h04, 8'h04);
		rd(CFG1_BASE + PTR_OFS, d); chk("reset point", 8'h00, d & 8'hf0);
		rd(CFG1_BASE + OUTS_OFS, d); chk("wait latch", 8'h3c, d);
		wait_st(8'h03, 8'h00);
		rd(CFG1_BASE + OUTS_OFS, d); chk("released flags", 8'h00, d);
		// output copy, read clear, stop with output enabled
		ev(2'b01, 8'h5a, 8'h00);
		prog(PROG1_BASE, 16'h8800, 2);
		run(2'b01);
		rd(CFG1_BASE + OUTS_OFS, d); chk("copy", 8'h5a, d);
		rd(CFG1_BASE + OUTS_OFS, d); chk("read clear", 8'h00, d);
		wr(CFG1_BASE + SETT_OFS, 8'h20);
		ev(2'b01, 8'h66, 8'h00);
		prog(PROG1_BASE, 8'h00, 1);
		run(2'b01);
		rd(CFG1_BASE + OUTS_OFS, d); chk("stop latch", 8'h66, d);
		// sync point holds program 1 while program 2 waits on the host
		wr(SETT1_ADDR, 8'h00);
		ev(2'b10, 8'hc3, 8'h81);
		prog(PROG1_BASE, 32'hff663c00, 4);
		chk("trig lane 2", 8'h81, stat.trig[1]);
		prog(PROG2_BASE, 24'h99ff00, 3);
		wr(CTRL_ADDR, 8'h03);
		wait_st(8'h18, 8'h18);
		rd(SETT1_ADDR, d); chk("sync hold", 8'h00, d);
		chk("park state", 8'h18, {2'h0, stat.wsync, stat.whost, stat.run});
		rd(CFG2_BASE + OUTS_OFS, d); chk("wait latch 2", 8'hc3, d);
		wait_st(8'h03, 8'h00);
		rd(SETT1_ADDR, d); chk("sync release", 8'h3c, d);
		finish_test();
	end
endmodule : test_motion_state_program_command_decoder
`default_nettype wire
